// ==== bench/ickb_match_model.sv ====
// Match engine side model that captures every key it is handed
`default_nettype none
module ickb_match_model (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    // Key from the builder
    input  wire logic         key_valid_reg,
    input  wire logic [376:0] key_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned  n_keys;
    logic [376:0] last_key;
    ////////////////////////////////////////
    // Capture each key on its valid pulse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            n_keys   <= 0;
            last_key <= '0;
        end else if (key_valid_reg) begin
            n_keys   <= n_keys + 1;
            last_key <= key_reg;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the full key builder
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys, reset_n, frame_valid, per_port_address_swap_enable;
    logic [1:0]   full_key_layout_select;
    logic [47:0]  frame_smac, frame_dmac;
    logic [15:0]  frame_type_len, l4_sport, l4_dport;
    logic [2:0]   frame_kind;
    logic [7:0]   llc_dsap, llc_ssap, ip_protocol;
    logic [39:0]  snap_pid;
    logic         frame_tagged, oam_masquerade, ip_more_frag, l4_is_tcp, l4_is_udp;
    logic [11:0]  frame_vid, port_default_vid;
    logic [6:0]   oam_meg_level;
    logic [5:0]   translated_dscp;
    logic [127:0] frame_sip, frame_dip, rng_low_flat, rng_high_flat;
    logic [12:0]  ip_frag_offset;
    logic [111:0] ip6_payload;
    logic [23:0]  rng_type_flat;
    logic         key_valid_reg, exp_v, bb;
    logic [376:0] key_reg, exp_k;
    int           seed = 91729;
    int           n_fail, total_checks, n_exp;
    ickb_key_builder dut_u (.clk_sys, .reset_n, .frame_valid, .full_key_layout_select,
        .per_port_address_swap_enable, .frame_smac, .frame_dmac, .frame_type_len,
        .frame_kind, .llc_dsap, .llc_ssap, .snap_pid, .frame_tagged, .frame_vid,
        .port_default_vid, .oam_masquerade, .oam_meg_level, .translated_dscp, .frame_sip,
        .frame_dip, .ip_protocol, .ip_more_frag, .ip_frag_offset, .l4_is_tcp, .l4_is_udp,
        .l4_sport, .l4_dport, .ip6_payload, .rng_type_flat, .rng_low_flat, .rng_high_flat,
        .key_valid_reg, .key_reg);
    ickb_match_model par_u (.clk_sys, .reset_n, .key_valid_reg, .key_reg);
    ////////////////////////////////////////
    function automatic logic [31:0] r32();
        return $random(seed);
    endfunction
    function automatic logic in_rng(input int n, input logic [15:0] v);
        return v >= rng_low_flat[16*n+:16] && v <= rng_high_flat[16*n+:16];
    endfunction
    // Reference key built from the current inputs
    function automatic logic [376:0] model_key();
        logic [376:0] k;
        logic         ip, tu;
        k = '0;
        ip = frame_kind == 3'h2 || frame_kind == 3'h3;
        tu = ip && (l4_is_tcp || l4_is_udp);
        k[1:0] = full_key_layout_select;
        k[25] = frame_type_len == 16'h8902;
        if (full_key_layout_select == 2'h0) begin
            k[112:65] = per_port_address_swap_enable ? frame_dmac : frame_smac;
            k[118:113] = translated_dscp;
            k[246:119] = per_port_address_swap_enable ? frame_dip : frame_sip;
            k[254:247] = ip_protocol;
            k[255] = tu;
            k[256] = ip && l4_is_tcp;
            for (int n = 0; n < 8; n++) begin
                case (rng_type_flat[3*n+:3])
                    3'h1: k[257+n] = in_rng(n, l4_sport);
                    3'h2: k[257+n] = in_rng(n, l4_dport);
                    3'h3: k[257+n] = in_rng(n, l4_sport) || in_rng(n, l4_dport);
                    3'h4: k[257+n] = in_rng(n, {4'h0, frame_tagged ? frame_vid : port_default_vid});
                    3'h5: k[257+n] = in_rng(n, {10'h000, translated_dscp});
                    default: k[257+n] = 1'b0;
                endcase
            end
            k[376:265] = ip6_payload;
        end else if (full_key_layout_select == 2'h1) begin
            k[112:65] = frame_dmac;
            k[160:113] = frame_smac;
            k[161] = frame_type_len >= 16'h0600;
            k[177:162] = k[25] ? {8'h89, oam_masquerade, oam_meg_level} :
                (frame_kind == 3'h0) ? {llc_dsap, llc_ssap} :
                (frame_kind == 3'h1) ? snap_pid[39:24] :
                tu ? l4_dport : ip ? {8'h00, ip_protocol} : frame_type_len;
            k[178] = ip || frame_kind == 3'h1;
            k[179] = frame_kind == 3'h2;
            k[180] = frame_kind == 3'h2 && (ip_more_frag || ip_frag_offset != 13'h0000);
        end
        return k;
    endfunction
    ////////////////////////////////////////
    task automatic drive_frame();
        logic [511:0] big;
        logic [1:0]   fs;
        logic [4:0]   b5;
        logic [31:0]  d;
        for (int i = 0; i < 16; i++) big[32*i+:32] = r32();
        {frame_smac, frame_dmac, snap_pid} = big[135:0];
        {frame_sip, frame_dip, ip6_payload} = big[503:136];
        {full_key_layout_select, per_port_address_swap_enable, frame_kind, frame_tagged,
            oam_masquerade, oam_meg_level, l4_is_tcp, l4_is_udp, ip_more_frag, frame_vid,
            fs} = r32();
        if (frame_kind > 3'h5) frame_kind = frame_kind - 3'h2;
        {frame_type_len, ip_protocol, llc_ssap} = r32();
        {llc_dsap, translated_dscp, ip_frag_offset, b5} = r32();
        if (b5[0]) ip_frag_offset = 13'h0000;
        if (b5[2:1] == 2'h0) frame_type_len = 16'h8902;
        if (b5[2:1] == 2'h1) frame_type_len = b5[3] ? 16'h0600 : 16'h05FF;
        {l4_sport, l4_dport} = r32() & 32'h00FF_00FF;
        {port_default_vid[7:0], rng_type_flat} = r32();
        port_default_vid[11:8] = 4'h0;
        for (int n = 0; n < 8; n++) begin
            d = r32();
            rng_low_flat[16*n+:16] = {8'h00, d[7:0]};
            rng_high_flat[16*n+:16] = {8'h00, d[7:0]} + {12'h000, d[11:8]};
        end
        if (b5[4]) l4_sport = rng_high_flat[15:0];
        frame_valid = bb || fs != 2'h0;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t key valid pulse wrong", $time);
        end
    endtask
    task automatic chk_key(input logic [376:0] got, input logic [376:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t key value wrong", $time);
        end
    endtask
    task automatic run_frames(input int cnt);
        repeat (cnt) begin
            drive_frame();
            if (frame_valid) exp_k = model_key();
            if (frame_valid) n_exp++;
            exp_v = frame_valid;
            @(negedge clk_sys);
            chk_bit(key_valid_reg, exp_v);
            chk_key(key_reg, exp_k);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #1ms;
        n_fail++;
        print_verdict();
    end
    initial begin
        bb = 1'b0;
        reset_n = 1'b0;
        drive_frame();
        exp_k = '0;
        repeat (16) @(negedge clk_sys);
        chk_key(key_reg, exp_k);
        reset_n = 1'b1;
        run_frames(1000);
        $display("random frame test done");
        reset_n = 1'b0;
        #1;
        chk_bit(key_valid_reg, 1'b0);
        chk_key(key_reg, '0);
        @(negedge clk_sys);
        reset_n = 1'b1;
        exp_k = '0;
        n_exp = 0;
        bb = 1'b1;
        run_frames(1000);
        frame_valid = 1'b0;
        @(negedge clk_sys);
        chk_key(377'(par_u.n_keys), 377'(n_exp));
        chk_key(par_u.last_key, exp_k);
        $display("back to back test done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== design/ickb_key_builder.sv ====
// Full key builder for the normal IPv6 and seven-tuple classification keys
// Behaviour
// - Normal key: source MAC at bit 65, destination MAC when swap enabled
// - Normal key: translated 6-bit DSCP at bit 113
// - Normal key: source IP at 119 (dest if swapped), next header at 247
// - Normal key: bit 255 IP TCP or UDP, bit 256 TCP only
// - Normal key: 8-bit range match mask at bit 257
// - Ranges compare frame ports, tagged or default VID, translated DSCP
// - Normal key: 112 payload bits after IPv6 header at bit 265
// - Seven-tuple: bit 161 set when type/length word at least 0x600
// - Seven-tuple: 16-bit type word at 162 chosen by frame kind
// - OAM frames: 0x89, masquerade bit, MEG level, OAM flag set
// - Seven-tuple: bit 178 for IPv4, IPv6 or SNAP; bit 179 IPv4
// - Seven-tuple: bit 180 when IPv4 more-fragments or offset nonzero
// - Two-bit layout field at bit 0: 0 normal, 1 seven, 2 five
// - Common key: OAM indicator at bit 25 for EtherType 0x8902
`default_nettype none
module ickb_key_builder (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    // Frame strobe and layout
    input  wire logic         frame_valid,
    input  wire logic [1:0]   full_key_layout_select,
    input  wire logic         per_port_address_swap_enable,
    // Layer 2 fields
    input  wire logic [47:0]  frame_smac,
    input  wire logic [47:0]  frame_dmac,
    input  wire logic [15:0]  frame_type_len,
    input  wire logic [2:0]   frame_kind,
    input  wire logic [7:0]   llc_dsap,
    input  wire logic [7:0]   llc_ssap,
    input  wire logic [39:0]  snap_pid,
    input  wire logic         frame_tagged,
    input  wire logic [11:0]  frame_vid,
    input  wire logic [11:0]  port_default_vid,
    // OAM fields
    input  wire logic         oam_masquerade,
    input  wire logic [6:0]   oam_meg_level,
    // Layer 3 and 4 fields
    input  wire logic [5:0]   translated_dscp,
    input  wire logic [127:0] frame_sip,
    input  wire logic [127:0] frame_dip,
    input  wire logic [7:0]   ip_protocol,
    input  wire logic         ip_more_frag,
    input  wire logic [12:0]  ip_frag_offset,
    input  wire logic         l4_is_tcp,
    input  wire logic         l4_is_udp,
    input  wire logic [15:0]  l4_sport,
    input  wire logic [15:0]  l4_dport,
    input  wire logic [111:0] ip6_payload,
    // Range checker configuration
    input  wire logic [23:0]  rng_type_flat,
    input  wire logic [127:0] rng_low_flat,
    input  wire logic [127:0] rng_high_flat,
    // Key output
    output logic              key_valid_reg,
    output logic [376:0]      key_reg
);
    ////////////////////////////////////////////////////////////////////////
    // Frame decode
    ickb_pkg::ickb_kind_t kind;
    logic                 is_ip;
    logic                 is_tcpudp;
    logic                 type_enc;
    logic                 is_oam;
    logic [7:0]           range_mask;
    logic [11:0]          range_vid;
    logic [376:0]         key_next;

    assign kind      = ickb_pkg::ickb_kind_t'(frame_kind);
    assign is_ip     = kind == ickb_pkg::KIND_IPV4 || kind == ickb_pkg::KIND_IPV6;
    assign is_tcpudp = is_ip && (l4_is_tcp || l4_is_udp);
    assign type_enc  = frame_type_len >= ickb_pkg::TYPE_MIN;
    assign is_oam    = frame_type_len == ickb_pkg::OAM_OVERLOADED_TYPE_WORD;
    assign range_vid = frame_tagged ? frame_vid : port_default_vid;

    ////////////////////////////////////////////////////////////////////////
    // Range checkers
    ickb_range_check u_rng (
        .sport         (l4_sport),
        .dport         (l4_dport),
        .vid           (range_vid),
        .dscp          (translated_dscp),
        .rng_type_flat (rng_type_flat),
        .rng_low_flat  (rng_low_flat),
        .rng_high_flat (rng_high_flat),
        .match_mask    (range_mask)
    );

    ////////////////////////////////////////////////////////////////////////
    // Key assembly
    always_comb begin
        key_next = ickb_pkg::KEY_RESET;
        key_next[ickb_pkg::OFS_LAYOUT +: 2] = full_key_layout_select;
        key_next[ickb_pkg::OFS_OAM] = is_oam;
        case (full_key_layout_select)
            ickb_pkg::LAYOUT_NORMAL: begin
                key_next[ickb_pkg::OFS_N_MAC +: 48] =
                    per_port_address_swap_enable ? frame_dmac : frame_smac;
                key_next[ickb_pkg::OFS_N_DSCP +: 6] = translated_dscp;
                key_next[ickb_pkg::OFS_N_IP +: 128] =
                    per_port_address_swap_enable ? frame_dip : frame_sip;
                key_next[ickb_pkg::OFS_N_NXTHDR +: 8] = ip_protocol;
                key_next[ickb_pkg::OFS_N_TCPUDP] = is_tcpudp;
                key_next[ickb_pkg::OFS_N_TCP] = is_ip && l4_is_tcp;
                key_next[ickb_pkg::OFS_N_RANGE +: 8] = range_mask;
                key_next[ickb_pkg::OFS_N_PAYLOAD +: 112] = ip6_payload;
            end
            ickb_pkg::LAYOUT_SEVEN: begin
                key_next[ickb_pkg::OFS_S_DMAC +: 48] = frame_dmac;
                key_next[ickb_pkg::OFS_S_SMAC +: 48] = frame_smac;
                key_next[ickb_pkg::OFS_S_TYPEENC] = type_enc;
                if (is_oam) begin
                    key_next[ickb_pkg::OFS_S_OVLTYPE +: 16] =
                        {ickb_pkg::OAM_HI_BYTE, oam_masquerade, oam_meg_level};
                end else if (kind == ickb_pkg::KIND_LLC) begin
                    key_next[ickb_pkg::OFS_S_OVLTYPE +: 16] = {llc_dsap, llc_ssap};
                end else if (kind == ickb_pkg::KIND_SNAP) begin
                    key_next[ickb_pkg::OFS_S_OVLTYPE +: 16] = snap_pid[39:24];
                end else if (is_tcpudp) begin
                    key_next[ickb_pkg::OFS_S_OVLTYPE +: 16] = l4_dport;
                end else if (is_ip) begin
                    key_next[ickb_pkg::OFS_S_OVLTYPE +: 16] = {8'h00, ip_protocol};
                end else begin
                    key_next[ickb_pkg::OFS_S_OVLTYPE +: 16] = frame_type_len;
                end
                key_next[ickb_pkg::OFS_S_IPSNAP] = is_ip || kind == ickb_pkg::KIND_SNAP;
                key_next[ickb_pkg::OFS_S_IPV4] = kind == ickb_pkg::KIND_IPV4;
                key_next[ickb_pkg::OFS_S_FRAG] = kind == ickb_pkg::KIND_IPV4
                    && (ip_more_frag || ip_frag_offset != 13'h0000);
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_valid_reg <= 1'b0;
        end else begin
            key_valid_reg <= frame_valid;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_reg <= ickb_pkg::KEY_RESET;
        end else if (frame_valid) begin
            key_reg <= key_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_norm_in;
        frame_valid && full_key_layout_select == ickb_pkg::LAYOUT_NORMAL;
    endsequence
    sequence s_seven_in;
        frame_valid && full_key_layout_select == ickb_pkg::LAYOUT_SEVEN;
    endsequence

    a_mac_swap: assert property (s_norm_in |=> key_valid_reg &&
        key_reg[65 +: 48] == ($past(per_port_address_swap_enable)
            ? $past(frame_dmac) : $past(frame_smac)))
        else $error("Normal key MAC field wrong");
    a_dscp_place: assert property (s_norm_in |=>
        key_reg[113 +: 6] == $past(translated_dscp))
        else $error("Normal key DSCP wrong");
    a_ip_swap: assert property (s_norm_in ##1 $past(per_port_address_swap_enable) |->
        key_reg[119 +: 128] == $past(frame_dip) && key_reg[247 +: 8] == $past(ip_protocol))
        else $error("Normal key IP or next header wrong");
    a_tcp_flags: assert property (s_norm_in |=>
        (!key_reg[256] || key_reg[255]) && key_reg[255] == $past(is_tcpudp)
        && key_reg[256] == ($past(is_ip) && $past(l4_is_tcp)))
        else $error("Normal key transport flags wrong");
    a_ip_direct: assert property (s_norm_in ##1 !$past(per_port_address_swap_enable) |->
        key_reg[119 +: 128] == $past(frame_sip))
        else $error("Normal key source IP wrong");
    a_range_mask: assert property (s_norm_in |=>
        key_reg[257 +: 8] == $past(range_mask))
        else $error("Range mask not placed");
    a_payload_place: assert property (s_norm_in |=>
        key_reg[265 +: 112] == $past(ip6_payload))
        else $error("Payload field wrong");
    a_seven_macs: assert property (s_seven_in |=>
        key_reg[65 +: 48] == $past(frame_dmac) && key_reg[113 +: 48] == $past(frame_smac))
        else $error("Seven-tuple MACs wrong");
    a_type_enc: assert property (s_seven_in |=>
        key_reg[161] == ($past(frame_type_len) >= 16'h0600))
        else $error("Type encoded flag wrong");
    a_oam_word: assert property (s_seven_in and frame_type_len == 16'h8902 |=>
        key_reg[162 +: 8] == {$past(oam_masquerade), $past(oam_meg_level)}
        && key_reg[170 +: 8] == 8'h89 && key_reg[25])
        else $error("OAM type word wrong");
    a_llc_word: assert property (s_seven_in and frame_kind == 3'h0
        and frame_type_len != 16'h8902 |=>
        key_reg[162 +: 16] == {$past(llc_dsap), $past(llc_ssap)})
        else $error("LLC type word wrong");
    a_ipv4_flags: assert property (s_seven_in and frame_kind == 3'h2 |=>
        key_reg[179] && key_reg[178])
        else $error("IPv4 flags wrong");
    a_snap_flag: assert property (s_seven_in |=>
        key_reg[178] == ($past(frame_kind) == 3'h1 || $past(frame_kind) == 3'h2
            || $past(frame_kind) == 3'h3))
        else $error("IP or SNAP flag wrong");
    a_frag_flag: assert property (s_seven_in and frame_kind == 3'h2 |=>
        key_reg[180] == ($past(ip_more_frag) || $past(ip_frag_offset) != 13'h0000))
        else $error("Fragment flag wrong");
    a_layout_field: assert property (frame_valid |=>
        key_reg[1:0] == $past(full_key_layout_select))
        else $error("Layout field wrong");
    a_five_empty: assert property (frame_valid && full_key_layout_select[1] |=>
        key_reg[376:26] == '0 && key_reg[24:2] == '0)
        else $error("Unused layout bits not zero");
    a_key_hold: assert property (!frame_valid |=> !key_valid_reg && $stable(key_reg))
        else $error("Key changed without a frame");
endmodule
`default_nettype wire

// ==== design/ickb_range_check.sv ====
// Eight range checkers producing the range match mask
`default_nettype none
module ickb_range_check (
    // Compared values
    input  wire logic [15:0] sport,
    input  wire logic [15:0] dport,
    input  wire logic [11:0] vid,
    input  wire logic [5:0]  dscp,
    // Per-checker configuration, checker n in slice n
    input  wire logic [23:0]  rng_type_flat,
    input  wire logic [127:0] rng_low_flat,
    input  wire logic [127:0] rng_high_flat,
    // One bit per checker
    output logic      [7:0]   match_mask
);
    genvar g;
    generate
        for (g = 0; g < ickb_pkg::RNG_N; g++) begin : g_rng
            logic [15:0]        lo;
            logic [15:0]        hi;
            ickb_pkg::ickb_rng_t ty;
            logic [15:0]        vid_w;
            logic [15:0]        dscp_w;
            logic               hit;
            assign lo     = rng_low_flat[16*g +: 16];
            assign hi     = rng_high_flat[16*g +: 16];
            assign ty     = ickb_pkg::ickb_rng_t'(rng_type_flat[3*g +: 3]);
            assign vid_w  = {4'h0, vid};
            assign dscp_w = {10'h000, dscp};
            always_comb begin
                case (ty)
                    ickb_pkg::RNG_SPORT:  hit = sport >= lo && sport <= hi;
                    ickb_pkg::RNG_DPORT:  hit = dport >= lo && dport <= hi;
                    ickb_pkg::RNG_EITHER: hit = (sport >= lo && sport <= hi)
                                             || (dport >= lo && dport <= hi);
                    ickb_pkg::RNG_VID:    hit = vid_w >= lo && vid_w <= hi;
                    ickb_pkg::RNG_DSCP:   hit = dscp_w >= lo && dscp_w <= hi;
                    default:              hit = 1'b0;
                endcase
            end
            assign match_mask[g] = hit;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== include/ickb_pkg.sv ====
// Constants for the ingress classifier full key builder
`default_nettype none
package ickb_pkg;
    // Key width and layout codes
    localparam int unsigned KEY_W          = 377;
    localparam logic [1:0]  LAYOUT_NORMAL  = 2'h0;
    localparam logic [1:0]  LAYOUT_SEVEN   = 2'h1;
    localparam logic [1:0]  LAYOUT_FIVE    = 2'h2;
    // Common key offsets
    localparam int unsigned OFS_LAYOUT     = 0;
    localparam int unsigned OFS_OAM        = 25;
    // Normal IPv6 key offsets
    localparam int unsigned OFS_N_MAC      = 65;
    localparam int unsigned OFS_N_DSCP     = 113;
    localparam int unsigned OFS_N_IP       = 119;
    localparam int unsigned OFS_N_NXTHDR   = 247;
    localparam int unsigned OFS_N_TCPUDP   = 255;
    localparam int unsigned OFS_N_TCP      = 256;
    localparam int unsigned OFS_N_RANGE    = 257;
    localparam int unsigned OFS_N_PAYLOAD  = 265;
    // Seven-tuple key offsets
    localparam int unsigned OFS_S_DMAC     = 65;
    localparam int unsigned OFS_S_SMAC     = 113;
    localparam int unsigned OFS_S_TYPEENC  = 161;
    localparam int unsigned OFS_S_OVLTYPE  = 162;
    localparam int unsigned OFS_S_IPSNAP   = 178;
    localparam int unsigned OFS_S_IPV4     = 179;
    localparam int unsigned OFS_S_FRAG     = 180;
    // Frame values
    localparam logic [15:0] TYPE_MIN       = 16'h0600;
    localparam logic [15:0] OAM_OVERLOADED_TYPE_WORD      = 16'h8902;
    localparam logic [7:0]  OAM_HI_BYTE    = 8'h89;
    localparam logic [KEY_W-1:0] KEY_RESET = '0;
    // Range checkers
    localparam int unsigned RNG_N          = 8;
    // Frame kinds from the parser
    typedef enum logic [2:0] {
        KIND_LLC, KIND_SNAP, KIND_IPV4, KIND_IPV6, KIND_ARP, KIND_OVERLOADED_TYPE_WORD
    } ickb_kind_t;
    // Range checker types
    typedef enum logic [2:0] {
        RNG_OFF, RNG_SPORT, RNG_DPORT, RNG_EITHER, RNG_VID, RNG_DSCP
    } ickb_rng_t;
endpackage
`default_nettype wire
